// ### hw/fan_enh_cfg_defs.vh
// constants for the enhanced fan configuration register block
// assumes inclusion by bare name from the design files
`ifndef FAN_ENH_CFG_DEFS_VH
`define FAN_ENH_CFG_DEFS_VH

// --------------------------------------------------------------------------
// register map (byte addresses on the apb word bus)
// --------------------------------------------------------------------------
`define ENH_CFG_IDX 8'h45
`define ENH_CFG_ADDR 12'h114
`define FAN_CFG_IDX 8'h4a
`define FAN_CFG_ADDR 12'h128
`define TEMP_LO_ADDR 12'h200
`define DUTY_CTRL_ADDR 12'h204
`define DUTY_STAT_ADDR 12'h208

// --------------------------------------------------------------------------
// fan_enhanced_config fields
// --------------------------------------------------------------------------
`define ENH_RSVD_BIT 7
`define ENH_FILT_BIT 6
`define ENH_TRES_BIT 5
`define ENH_FINE_BIT 4
`define ENH_USF_BIT 3
`define ENH_RATE_HI 2
`define ENH_RATE_LO 1
`define ENH_SMEN_BIT 0
`define ENH_RESET 8'h00
`define ENH_WR_MASK 8'h7f
`define ENH_LOCK_MASK 8'h07

// --------------------------------------------------------------------------
// fan configuration (only the programming enable lives here)
// --------------------------------------------------------------------------
`define FAN_PGM_BIT 5
`define FAN_CFG_RESET 8'h20

// --------------------------------------------------------------------------
// duty control register fields
// --------------------------------------------------------------------------
`define DCTL_FREQ_BIT 0
`define DCTL_SPIN_BIT 1
`define DCTL_CRIT_BIT 2
`define DCTL_TGT_LO 8
`define DCTL_TGT_HI 15

// --------------------------------------------------------------------------
// timing: ramp step times in microseconds, clock 20 MHz
// --------------------------------------------------------------------------
`define CLK_HZ 20000000
`define STEP0_US 23000
`define STEP1_US 46000
`define STEP2_US 910000
`define STEP3_US 182000
`define STEP0_CYC (`STEP0_US * (`CLK_HZ / 1000000))
`define STEP1_CYC (`STEP1_US * (`CLK_HZ / 1000000))
`define STEP2_CYC (`STEP2_US * (`CLK_HZ / 1000000))
`define STEP3_CYC (`STEP3_US * (`CLK_HZ / 1000000))

`endif

// ### hw/duty_ramp.v
// duty-cycle smoothing engine: walks the applied duty toward a target
// assumes a step tick and control levels from the register block
`timescale 1ns/1ps
`include "fan_enh_cfg_defs.vh"

module duty_ramp #(
  parameter WIDTH = 8
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire ce_i,
  input wire smooth_i,
  input wire tick_i,
  input wire [WIDTH-1:0] target_i,
  output reg [WIDTH-1:0] duty_o
);

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      duty_o <= {WIDTH{1'b0}};
    end else if (ce_i) begin
      if (!smooth_i) begin
        duty_o <= target_i;
      end else if (tick_i && duty_o < target_i) begin
        duty_o <= duty_o + {{(WIDTH-1){1'b0}}, 1'b1};
      end else if (tick_i && duty_o > target_i) begin
        duty_o <= duty_o - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // duty_ramp

// ### hw/fan_enhanced_config_register.v
// enhanced fan configuration register with apb slave and smoothing control
// assumes apb master on clk_i; temperature and spin/crit status from fan core
`timescale 1ns/1ps
`include "fan_enh_cfg_defs.vh"

module fan_enhanced_config_register #(
  parameter STEP0 = `STEP0_CYC,
  parameter STEP1 = `STEP1_CYC,
  parameter STEP2 = `STEP2_CYC,
  parameter STEP3 = `STEP3_CYC
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire ce_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  input wire [7:0] temp_lo_raw_i,
  input wire filter_active_i,
  input wire spin_up_i,
  input wire crit_override_i,
  output reg filtered_temp_bits_enable_o,
  output reg table_temp_resolution_ext_o,
  output reg fine_duty_resolution_o,
  output reg setpoint_unsigned_format_o,
  output reg [7:0] temp_lo_o,
  output reg [7:0] duty_o
);

  // --------------------------------------------------------------------------
  // reset release
  // --------------------------------------------------------------------------
  reg rst_s1_reg;
  reg rst_s2_reg;
  wire rst_b;

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign rst_b = rst_s2_reg;

  // --------------------------------------------------------------------------
  // pin synchronisers for status inputs
  // --------------------------------------------------------------------------
  reg [2:0] spin_sync_reg;
  reg [2:0] crit_sync_reg;
  reg spin_reg;
  reg crit_reg;

  always @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      spin_sync_reg <= 3'h0;
      crit_sync_reg <= 3'h0;
      spin_reg <= 1'b0;
      crit_reg <= 1'b0;
    end else if (ce_i) begin
      spin_sync_reg <= {spin_sync_reg[1:0], spin_up_i};
      crit_sync_reg <= {crit_sync_reg[1:0], crit_override_i};
      // a change counts only once stages two and three agree
      if (spin_sync_reg[1] == spin_sync_reg[2]) begin
        spin_reg <= spin_sync_reg[2];
      end
      if (crit_sync_reg[1] == crit_sync_reg[2]) begin
        crit_reg <= crit_sync_reg[2];
      end
    end
  end

  // --------------------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------------------
  reg [7:0] enh_reg;
  reg [7:0] fan_cfg_reg;
  reg [7:0] target_reg;
  reg freq_22k_reg;
  wire [7:0] ramp_duty;

  wire access = psel_i && penable_i && !pready_o;
  wire wr = access && pwrite_i;
  wire pgm_en = fan_cfg_reg[`FAN_PGM_BIT];

  function addr_known;
    input [11:0] a;
    begin
      addr_known = (a == `ENH_CFG_ADDR) || (a == `FAN_CFG_ADDR) ||
                   (a == `TEMP_LO_ADDR) || (a == `DUTY_CTRL_ADDR) ||
                   (a == `DUTY_STAT_ADDR);
    end
  endfunction

  // --------------------------------------------------------------------------
  // register writes
  // --------------------------------------------------------------------------
  reg [7:0] enh_next;
  reg [7:0] wmask;

  always @* begin
    // locked fields keep their value; bit 7 never stores
    wmask = pgm_en ? `ENH_WR_MASK : (`ENH_WR_MASK & ~`ENH_LOCK_MASK);
    enh_next = (enh_reg & ~wmask) | (pwdata_i[7:0] & wmask);
  end

  always @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      enh_reg <= `ENH_RESET;
      fan_cfg_reg <= `FAN_CFG_RESET;
      target_reg <= 8'h00;
      freq_22k_reg <= 1'b0;
    end else if (ce_i && wr) begin
      if (paddr_i == `ENH_CFG_ADDR) begin
        enh_reg <= enh_next;
      end else if (paddr_i == `FAN_CFG_ADDR) begin
        fan_cfg_reg <= pwdata_i[7:0] & 8'h3f;
      end else if (paddr_i == `DUTY_CTRL_ADDR) begin
        freq_22k_reg <= pwdata_i[`DCTL_FREQ_BIT];
        if (pgm_en) begin
          target_reg <= pwdata_i[`DCTL_TGT_HI:`DCTL_TGT_LO];
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // apb read and answer (one wait state: ready in the access cycle's next)
  // --------------------------------------------------------------------------
  always @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      prdata_o <= 32'h00000000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else if (ce_i) begin
      pready_o <= access;
      pslverr_o <= access && !addr_known(paddr_i);
      prdata_o <= 32'h00000000;
      if (access && !pwrite_i) begin
        if (paddr_i == `ENH_CFG_ADDR) begin
          prdata_o <= {24'h000000, 1'b0, enh_reg[6:0]};
        end else if (paddr_i == `FAN_CFG_ADDR) begin
          prdata_o <= {24'h000000, fan_cfg_reg};
        end else if (paddr_i == `TEMP_LO_ADDR) begin
          prdata_o <= {24'h000000, temp_lo_o};
        end else if (paddr_i == `DUTY_CTRL_ADDR) begin
          prdata_o <= {16'h0000, target_reg, 5'h00, crit_reg, spin_reg,
                       freq_22k_reg};
        end else if (paddr_i == `DUTY_STAT_ADDR) begin
          prdata_o <= {24'h000000, duty_o};
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // ramp step timer
  // --------------------------------------------------------------------------
  reg [24:0] step_cnt_reg;
  reg tick_reg;
  reg [24:0] step_len;

  always @* begin
    case (enh_reg[`ENH_RATE_HI:`ENH_RATE_LO])
      2'b00: step_len = STEP0[24:0];
      2'b01: step_len = STEP1[24:0];
      2'b10: step_len = STEP2[24:0];
      default: step_len = STEP3[24:0];
    endcase
  end

  wire smooth = enh_reg[`ENH_SMEN_BIT] && freq_22k_reg &&
                !spin_reg && !crit_reg;

  always @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      step_cnt_reg <= 25'h0000000;
      tick_reg <= 1'b0;
    end else if (ce_i) begin
      tick_reg <= 1'b0;
      if (!smooth || step_cnt_reg + 25'h0000001 >= step_len) begin
        step_cnt_reg <= 25'h0000000;
        tick_reg <= smooth;
      end else begin
        step_cnt_reg <= step_cnt_reg + 25'h0000001;
      end
    end
  end

  duty_ramp #(
    .WIDTH(8)
  ) u_ramp (
    .clk_i(clk_i),
    .rst_b_i(rst_b),
    .ce_i(ce_i),
    .smooth_i(smooth),
    .tick_i(tick_reg),
    .target_i(target_reg),
    .duty_o(ramp_duty)
  );

  // --------------------------------------------------------------------------
  // registered outputs
  // --------------------------------------------------------------------------
  wire fine = enh_reg[`ENH_FINE_BIT] && freq_22k_reg;

  always @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      filtered_temp_bits_enable_o <= 1'b0;
      table_temp_resolution_ext_o <= 1'b0;
      fine_duty_resolution_o <= 1'b0;
      setpoint_unsigned_format_o <= 1'b0;
      temp_lo_o <= 8'h00;
      duty_o <= 8'h00;
    end else if (ce_i) begin
      filtered_temp_bits_enable_o <= enh_reg[`ENH_FILT_BIT];
      table_temp_resolution_ext_o <= enh_reg[`ENH_TRES_BIT];
      fine_duty_resolution_o <= fine;
      setpoint_unsigned_format_o <= enh_reg[`ENH_USF_BIT];
      temp_lo_o <= temp_lo_raw_i;
      if (!(enh_reg[`ENH_FILT_BIT] && filter_active_i)) begin
        temp_lo_o[4:3] <= 2'b00;
      end
      // coarse mode keeps only the 16-step upper nibble
      duty_o <= fine ? ramp_duty : {ramp_duty[7:4], 4'h0};
    end
  end

endmodule // fan_enhanced_config_register

// ### tb/fan_enh_chk.sv
// checker for the enhanced fan configuration block, bound to its top
// assumes the port names of fan_enhanced_config_register
`timescale 1ns/1ps
`include "fan_enh_cfg_defs.vh"
module fan_enh_chk (
  input wire clk_i,
  input wire rst_b_i,
  input wire ce_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  input wire filtered_temp_bits_enable_o,
  input wire fine_duty_resolution_o,
  input wire [7:0] temp_lo_o,
  input wire [7:0] duty_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  wire mapped = paddr_i inside {`ENH_CFG_ADDR, `FAN_CFG_ADDR,
    `TEMP_LO_ADDR, `DUTY_CTRL_ADDR, `DUTY_STAT_ADDR};
  AST_ANSWER: assert property (psel_i && penable_i && !pready_o && ce_i
    |=> pready_o) else $error("no answer after access phase");
  AST_PULSE: assert property (pready_o && ce_i |=> !pready_o)
    else $error("ready held longer than one cycle");
  AST_RSVD: assert property (pready_o && !pwrite_i && paddr_i ==
    `ENH_CFG_ADDR |-> prdata_o[31:7] == 25'h0) else $error("bit 7 set");
  AST_IDLE: assert property (!pready_o |-> prdata_o == 32'h0 && !pslverr_o)
    else $error("read data outside answer");
  AST_UNMAP: assert property (pready_o && !mapped |-> pslverr_o &&
    prdata_o == 32'h0) else $error("unmapped access not refused");
  AST_FILT: assert property ((!filtered_temp_bits_enable_o)[*3]
    |-> temp_lo_o[4:3] == 2'b00) else $error("filter bits visible");
  AST_COARSE: assert property ((!fine_duty_resolution_o)[*3]
    |-> duty_o[3:0] == 4'h0) else $error("coarse duty has low bits");
  AST_RST: assert property ($rose(rst_b_i) |-> ##1 duty_o == 8'h0 &&
    !pready_o) else $error("outputs active right after reset");
  cover property (pready_o && pslverr_o);
  cover property (pready_o && pwrite_i && paddr_i == `ENH_CFG_ADDR);
  cover property ($changed(duty_o) && fine_duty_resolution_o);
endmodule // fan_enh_chk

bind fan_enhanced_config_register fan_enh_chk chk (.clk_i(clk_i),
  .rst_b_i(rst_b_i), .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o),
  .filtered_temp_bits_enable_o(filtered_temp_bits_enable_o),
  .fine_duty_resolution_o(fine_duty_resolution_o),
  .temp_lo_o(temp_lo_o), .duty_o(duty_o));

// ### tb/fan_core_model.sv
// fan core stand-in: temperature byte and spin-up/override status
// assumes the bench selects the status through mode_i
`timescale 1ns/1ps
module fan_core_model (
  input wire [3:0] mode_i,
  output wire [7:0] temp_raw_o,
  output wire filter_o,
  output wire spin_o,
  output wire crit_o
);
  // all ones so that masked filter bits show up
  assign temp_raw_o = 8'hff;
  assign filter_o = mode_i[0];
  assign spin_o = mode_i[1];
  assign crit_o = mode_i[2];
endmodule // fan_core_model

// ### tb/testbench.sv
// apb-driven bench for the enhanced fan configuration block
// assumes short step parameters 4, 8, 16, 32 cycles
`timescale 1ns/1ps
`include "fan_enh_cfg_defs.vh"
module testbench;
  logic clk_i = 0, rst_b_i = 0, psel = 0, pen = 0, pwr = 0, perr, e;
  logic [11:0] pa = 0;
  logic [31:0] pwd = 0, prd, rd;
  logic pready, filt, tres, fine, setpoint_unsigned_format, f_act, spin, crit;
  logic [7:0] raw, temp, duty, b;
  logic [3:0] mode = 0;
  logic ce = 1;
  int failures = 0, checks_done = 0;
  int st[4] = '{4, 8, 16, 32};
  fan_core_model core (.mode_i(mode), .temp_raw_o(raw), .filter_o(f_act),
    .spin_o(spin), .crit_o(crit));
  fan_enhanced_config_register #(.STEP0(4), .STEP1(8), .STEP2(16),
    .STEP3(32)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa),
    .pwdata_i(pwd), .prdata_o(prd), .pready_o(pready), .pslverr_o(perr),
    .temp_lo_raw_i(raw), .filter_active_i(f_act), .spin_up_i(spin),
    .crit_override_i(crit), .filtered_temp_bits_enable_o(filt),
    .table_temp_resolution_ext_o(tres), .fine_duty_resolution_o(fine),
    .setpoint_unsigned_format_o(setpoint_unsigned_format), .temp_lo_o(temp), .duty_o(duty));
  initial forever #25 clk_i = ~clk_i;
  task automatic chk(input string nm, input logic [31:0] ex, got);
    checks_done++;
    if (got !== ex) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", nm, ex, got);
    end
  endtask
  // entered just after a clock edge; leaves one idle edge behind it
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    int n = 0;
    psel <= 1; pwr <= w; pa <= a; pwd <= d;
    @(posedge clk_i);
    pen <= 1;
    do @(posedge clk_i); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50) failures++;
    rd = prd;
    e = perr;
    psel <= 0; pen <= 0;
    @(posedge clk_i);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] ex);
    apb(0, a, 0);
    chk("read", ex, rd);
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    end_sim();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1;
    repeat (3) @(posedge clk_i);
    rchk(`ENH_CFG_ADDR, 32'h0);
    rchk(`FAN_CFG_ADDR, 32'h20);
    mode <= 4'h1;
    apb(1, `ENH_CFG_ADDR, 32'hffff_ffff);
    rchk(`ENH_CFG_ADDR, 32'h7f);
    chk("outs", 3'b111, {filt, tres, setpoint_unsigned_format});
    rchk(`TEMP_LO_ADDR, 32'hff);
    mode <= 4'h0;
    rchk(`TEMP_LO_ADDR, 32'he7);
    apb(0, 12'h3fc, 0);
    chk("err", 1, e);
    chk("err data", 0, rd);
    // locked: smoothing fields and target keep their values
    apb(1, `FAN_CFG_ADDR, 32'h0);
    apb(1, `ENH_CFG_ADDR, 32'h0);
    rchk(`ENH_CFG_ADDR, 32'h07);
    // filter running but visibility bit clear: bits stay masked
    mode <= 4'h1;
    rchk(`TEMP_LO_ADDR, 32'he7);
    mode <= 4'h0;
    apb(1, `DUTY_CTRL_ADDR, 32'ha501);
    rchk(`DUTY_CTRL_ADDR, 32'h01);
    apb(1, `FAN_CFG_ADDR, 32'h20);
    apb(1, `ENH_CFG_ADDR, 32'h10);
    chk("fine", 1, fine);
    chk("outs", 3'b000, {filt, tres, setpoint_unsigned_format});
    apb(1, `DUTY_CTRL_ADDR, 32'h0);
    chk("fine", 0, fine);
    apb(1, `DUTY_CTRL_ADDR, 32'h1);
    for (int r = 0; r < 4; r++) begin
      apb(1, `ENH_CFG_ADDR, 32'h11 | (r << 1));
      b = duty;
      apb(1, `DUTY_CTRL_ADDR, {16'h0, b + 8'd16, 8'h01});
      repeat (8 * st[r]) @(posedge clk_i);
      chk("mid", 1, duty >= b + 7 && duty <= b + 9);
      repeat (10 * st[r]) @(posedge clk_i);
      chk("end", b + 8'd16, duty);
    end
    apb(1, `ENH_CFG_ADDR, 32'h10);
    apb(1, `DUTY_CTRL_ADDR, 32'h8001);
    repeat (3) @(posedge clk_i);
    chk("off", 8'h80, duty);
    rchk(`DUTY_STAT_ADDR, 32'h80);
    apb(1, `ENH_CFG_ADDR, 32'h11);
    for (int k = 1; k < 3; k++) begin
      mode <= 4'(k << 1);
      repeat (8) @(posedge clk_i);
      apb(1, `DUTY_CTRL_ADDR, {16'h0, 8'(k << 5), 8'h01});
      rchk(`DUTY_CTRL_ADDR, (k << 13) | (1 << k) | 1);
      repeat (6) @(posedge clk_i);
      chk("ovr", 8'(k << 5), duty);
    end
    mode <= 4'h0;
    apb(1, `DUTY_CTRL_ADDR, 32'ha000);
    repeat (6) @(posedge clk_i);
    chk("slow", 8'ha0, duty);
    // clock enable low must freeze the temperature path
    apb(1, `ENH_CFG_ADDR, 32'h51);
    mode <= 4'h1;
    repeat (4) @(posedge clk_i);
    chk("temp", 8'hff, temp);
    ce <= 0;
    mode <= 4'h0;
    repeat (6) @(posedge clk_i);
    chk("frozen", 8'hff, temp);
    ce <= 1;
    repeat (3) @(posedge clk_i);
    chk("thawed", 8'he7, temp);
    // second reset in mid-run restores the power-on state
    rst_b_i <= 0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1;
    repeat (3) @(posedge clk_i);
    rchk(`ENH_CFG_ADDR, 32'h0);
    rchk(`FAN_CFG_ADDR, 32'h20);
    chk("rst duty", 8'h00, duty);
    end_sim();
  end
endmodule // testbench
